/* common/cmtp_pkg.sv */
`default_nettype none
package cmtp_pkg;

  localparam int ADDR_W         = 32;
  localparam int WORD_W         = 32;
  localparam int BEAT_W         = 64;
  localparam int LINE_OFS_W     = 5;
  localparam int BEAT_LSB       = 3;
  localparam int HALF_LSB       = 2;
  localparam int BEATS_PER_LINE = 4;
  localparam int BEAT_CNT_W     = 2;
  localparam int NUM_LINES      = 4;
  localparam int IDX_W          = 2;
  localparam int TAG_W          = ADDR_W - IDX_W - LINE_OFS_W;
  localparam int WBUF_DEPTH     = 8;
  localparam int WBUF_PTR_W     = 3;
  localparam int WBUF_CNT_W     = 4;

  localparam logic [BEAT_CNT_W-1:0] LAST_BEAT = 2'h3;
  localparam logic [7:0]            BE_ALL    = 8'hFF;
  localparam logic [7:0]            BE_LO     = 8'h0F;
  localparam logic [7:0]            BE_HI     = 8'hF0;

  typedef enum logic [2:0] {
    type_uncached,
    type_combining,
    type_write_thru,
    type_write_back,
    type_write_prot
  } cmtp_mtype_e;

  typedef enum logic [2:0] {
    cmd_none,
    cmd_rd_word,
    cmd_rd_line,
    cmd_wr_word,
    cmd_wr_line
  } cmtp_cmd_e;

endpackage : cmtp_pkg
`default_nettype wire

/* common/cmtp_wbuf_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface cmtp_wbuf_if;
  import cmtp_pkg::*;
  logic                push_valid;
  logic                push_ready;
  logic                push_merge;
  logic [ADDR_W-1:0]   push_addr;
  logic [WORD_W-1:0]   push_data;
  logic                pop_valid;
  logic                pop_ready;
  logic [ADDR_W-1:0]   pop_addr;
  logic [WORD_W-1:0]   pop_data;
  logic                empty;

  modport store (input push_valid, push_merge, push_addr, push_data, pop_ready,
                 output push_ready, pop_valid, pop_addr, pop_data, empty);
  modport user  (output push_valid, push_merge, push_addr, push_data, pop_ready,
                 input push_ready, pop_valid, pop_addr, pop_data, empty);
endinterface : cmtp_wbuf_if
`default_nettype wire

/* rtl/cmtp_wbuf.sv */
`timescale 1ns/1ps
`default_nettype none
module cmtp_wbuf
  import cmtp_pkg::*;
(
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  sys_rst,
  input  wire logic  ce,
  // Queue ports
  cmtp_wbuf_if.store wb
);

  logic [ADDR_W-1:0]     addr_r [WBUF_DEPTH];
  logic [WORD_W-1:0]     data_r [WBUF_DEPTH];
  logic [WBUF_PTR_W-1:0] head_r;
  logic [WBUF_PTR_W-1:0] tail_r;
  logic [WBUF_CNT_W-1:0] cnt_r;
  logic [WBUF_PTR_W-1:0] last_idx;
  logic                  merge_hit;
  logic                  do_push;
  logic                  do_pop;

  // Only merge into an entry that is not at the head: the head may be on the bus
  assign last_idx      = WBUF_PTR_W'(tail_r - 1'b1);
  assign merge_hit     = wb.push_merge && (cnt_r > WBUF_CNT_W'(1))
                         && (addr_r[last_idx] == wb.push_addr);
  assign wb.push_ready = merge_hit || (cnt_r != WBUF_CNT_W'(WBUF_DEPTH));
  assign wb.empty      = (cnt_r == '0);
  assign wb.pop_valid  = !wb.empty;
  assign wb.pop_addr   = addr_r[head_r];
  assign wb.pop_data   = data_r[head_r];
  assign do_push       = wb.push_valid && wb.push_ready && !merge_hit;
  assign do_pop        = wb.pop_ready && wb.pop_valid;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      head_r <= '0;
      tail_r <= '0;
      cnt_r  <= '0;
    end
    else if (ce)
    begin
      if (do_push)
        tail_r <= WBUF_PTR_W'(tail_r + 1'b1);
      if (do_pop)
        head_r <= WBUF_PTR_W'(head_r + 1'b1);
      cnt_r <= WBUF_CNT_W'(cnt_r + {3'h0, do_push} - {3'h0, do_pop});
    end
  end

  always_ff @(posedge clk)
  begin
    if (ce && wb.push_valid && merge_hit)
      data_r[last_idx] <= wb.push_data;
    else if (ce && do_push)
    begin
      addr_r[tail_r] <= wb.push_addr;
      data_r[tail_r] <= wb.push_data;
    end
  end

endmodule : cmtp_wbuf
`default_nettype wire

/* rtl/cmtp_cache_policy.sv */
`timescale 1ns/1ps
`default_nettype none
module cmtp_cache_policy
  import cmtp_pkg::*;
(
  // Clock, reset, enable
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               ce,
  // Core access port
  input  wire logic               req_valid,
  output logic                    req_ready,
  input  wire logic               req_write,
  input  wire logic               req_spec,
  input  wire cmtp_mtype_e        req_type,
  input  wire logic [ADDR_W-1:0]  req_addr,
  input  wire logic [WORD_W-1:0]  req_wdata,
  output logic                    rsp_valid,
  output logic [WORD_W-1:0]       rsp_rdata,
  // Snoop port
  input  wire logic               snp_valid,
  output logic                    snp_ready,
  input  wire logic [ADDR_W-1:0]  snp_addr,
  input  wire logic               snp_write,
  output logic                    snp_hit,
  output logic                    snoop_hit_modified_n,
  // System bus master
  output logic                    bus_req,
  input  wire logic               bus_gnt,
  output cmtp_cmd_e               bus_cmd,
  output logic [ADDR_W-1:0]       bus_addr,
  output logic [BEAT_W-1:0]       bus_wdata,
  output logic [7:0]              bus_be,
  input  wire logic               bus_ack,
  input  wire logic               bus_rvalid,
  input  wire logic [BEAT_W-1:0]  bus_rdata
);

  typedef enum {st_idle, st_req, st_xfer, st_done} cmtp_state_e;

  cmtp_wbuf_if wb ();

  cmtp_wbuf u_wbuf (
    .clk     (clk),
    .sys_rst (sys_rst),
    .ce      (ce),
    .wb      (wb.store)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Line storage and helpers

  logic [NUM_LINES-1:0]  valid_r;
  logic [NUM_LINES-1:0]  dirty_r;
  logic [TAG_W-1:0]      tag_r [NUM_LINES];
  logic [BEAT_W-1:0]     data_r [NUM_LINES][BEATS_PER_LINE];

  function automatic logic [IDX_W-1:0] f_idx(input logic [ADDR_W-1:0] a);
    return a[LINE_OFS_W +: IDX_W];
  endfunction : f_idx

  function automatic logic [TAG_W-1:0] f_tag(input logic [ADDR_W-1:0] a);
    return a[ADDR_W-1 -: TAG_W];
  endfunction : f_tag

  function automatic logic [BEAT_CNT_W-1:0] f_beat(input logic [ADDR_W-1:0] a);
    return a[BEAT_LSB +: BEAT_CNT_W];
  endfunction : f_beat

  function automatic logic [ADDR_W-1:0] f_base(input logic [ADDR_W-1:0] a);
    return {a[ADDR_W-1:LINE_OFS_W], {LINE_OFS_W{1'b0}}};
  endfunction : f_base

  function automatic logic f_hit(input logic [ADDR_W-1:0] a);
    return valid_r[f_idx(a)] && (tag_r[f_idx(a)] == f_tag(a));
  endfunction : f_hit

  function automatic logic [WORD_W-1:0] f_word(input logic [BEAT_W-1:0] d,
                                               input logic [ADDR_W-1:0] a);
    return a[HALF_LSB] ? d[BEAT_W-1 -: WORD_W] : d[WORD_W-1:0];
  endfunction : f_word

  ////////////////////////////////////////////////////////////////////////////////
  // Request decode

  cmtp_state_e           state_r;
  cmtp_cmd_e             op_r;
  logic [ADDR_W-1:0]     op_addr_r;
  logic [BEAT_CNT_W-1:0] beat_r;
  logic                  iwb_r;
  logic [ADDR_W-1:0]     rq_addr_r;
  logic [WORD_W-1:0]     rq_wdata_r;
  logic                  rq_write_r;
  logic [BEAT_W-1:0]     rd_beat_r;
  logic                  snoop_hit_modified_n_r;
  logic                  snp_hit_r;
  logic                  rsp_valid_r;
  logic [WORD_W-1:0]     rsp_rdata_r;
  logic [BEAT_W-1:0]     bus_wdata_r;
  logic [7:0]            bus_be_r;

  logic [IDX_W-1:0]      rq_idx;
  logic                  rq_hit;
  logic                  rq_cacheable;
  logic                  needs_rd;
  logic                  needs_push;
  logic                  vict_dirty;
  logic                  acc;
  logic                  snp_take;
  logic                  snp_dirty;
  logic                  drain_go;
  logic                  beat_go;
  logic [IDX_W-1:0]      op_idx;

  assign rq_idx       = f_idx(req_addr);
  assign rq_hit       = f_hit(req_addr);
  // Memory type arrives resolved with each access; any region may use any type
  assign rq_cacheable = (req_type == type_write_thru) || (req_type == type_write_back)
                        || (req_type == type_write_prot);
  // Only write-back allocates on a write miss; other writes go to the buffer
  assign needs_rd     = req_write ? (req_type == type_write_back) && !rq_hit
                                  : !(rq_cacheable && rq_hit);
  assign needs_push   = req_write && (req_type != type_write_back);
  assign vict_dirty   = valid_r[rq_idx] && dirty_r[rq_idx];
  // Bus reads wait for an empty buffer so reads and writes keep program order
  assign req_ready    = (state_r == st_idle) && !snp_valid
                        && !(req_type == type_uncached && req_spec)
                        && (!needs_rd || wb.empty)
                        && (!needs_push || wb.push_ready);
  assign snp_ready    = (state_r == st_idle);
  assign acc          = ce && req_valid && req_ready;
  assign snp_take     = ce && snp_valid && snp_ready;
  assign snp_dirty    = f_hit(snp_addr) && dirty_r[f_idx(snp_addr)];
  assign drain_go     = ce && (state_r == st_idle) && !acc && !snp_take && !wb.empty;
  assign beat_go      = (op_r == cmd_rd_line || op_r == cmd_rd_word) ? bus_rvalid : bus_ack;
  assign op_idx       = f_idx(op_addr_r);

  // Combining allowed for combining and write-through; never for uncached
  assign wb.push_valid = acc && needs_push;
  assign wb.push_merge = (req_type == type_combining) || (req_type == type_write_thru);
  assign wb.push_addr  = req_addr;
  assign wb.push_data  = req_wdata;
  assign wb.pop_ready  = ce && (state_r == st_done) && (op_r == cmd_wr_word);

  ////////////////////////////////////////////////////////////////////////////////
  // Bus sequencer

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      state_r   <= st_idle;
      op_r      <= cmd_none;
      op_addr_r <= '0;
      beat_r    <= '0;
      iwb_r     <= 1'b0;
    end
    else if (ce)
    begin
      case (state_r)
        st_idle:
        begin
          if (snp_take && snp_dirty)
          begin
            state_r   <= st_req;
            op_r      <= cmd_wr_line;
            op_addr_r <= f_base(snp_addr);
            iwb_r     <= 1'b1;
          end
          else if (acc && needs_rd)
          begin
            state_r <= st_req;
            iwb_r   <= 1'b0;
            if (!rq_cacheable)
            begin
              op_r      <= cmd_rd_word;
              op_addr_r <= req_addr;
            end
            else if (vict_dirty)
            begin
              op_r      <= cmd_wr_line;
              op_addr_r <= {tag_r[rq_idx], rq_idx, {LINE_OFS_W{1'b0}}};
            end
            else
            begin
              op_r      <= cmd_rd_line;
              op_addr_r <= f_base(req_addr);
            end
          end
          else if (drain_go)
          begin
            state_r   <= st_req;
            op_r      <= cmd_wr_word;
            op_addr_r <= wb.pop_addr;
          end
        end
        st_req:
        begin
          if (bus_gnt)
          begin
            state_r <= st_xfer;
            beat_r  <= '0;
          end
        end
        st_xfer:
        begin
          if (beat_go)
          begin
            if ((op_r == cmd_rd_line || op_r == cmd_wr_line) && beat_r != LAST_BEAT)
              beat_r <= BEAT_CNT_W'(beat_r + 1'b1);
            else
              state_r <= st_done;
          end
        end
        st_done:
        begin
          // A replaced victim is followed by the fill of the missing line
          if (op_r == cmd_wr_line && !iwb_r)
          begin
            state_r   <= st_req;
            op_r      <= cmd_rd_line;
            op_addr_r <= f_base(rq_addr_r);
          end
          else
          begin
            state_r <= st_idle;
            iwb_r   <= 1'b0;
          end
        end
        default:
          state_r <= st_idle;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rq_addr_r  <= '0;
      rq_wdata_r <= '0;
      rq_write_r <= 1'b0;
    end
    else if (acc)
    begin
      rq_addr_r  <= req_addr;
      rq_wdata_r <= req_wdata;
      rq_write_r <= req_write;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Line state

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      valid_r <= '0;
      dirty_r <= '0;
    end
    else if (ce)
    begin
      if (acc && req_write && rq_hit)
      begin
        if (req_type == type_write_back)
          dirty_r[rq_idx] <= 1'b1;
        else if (req_type == type_write_prot)
          valid_r[rq_idx] <= 1'b0;
      end
      if (snp_take && f_hit(snp_addr))
      begin
        dirty_r[f_idx(snp_addr)] <= 1'b0;
        if (snp_write)
          valid_r[f_idx(snp_addr)] <= 1'b0;
      end
      if (state_r == st_done && op_r == cmd_rd_line)
      begin
        valid_r[op_idx] <= 1'b1;
        dirty_r[op_idx] <= rq_write_r;
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (ce && state_r == st_done && op_r == cmd_rd_line)
      tag_r[op_idx] <= f_tag(op_addr_r);
  end

  always_ff @(posedge clk)
  begin
    if (ce)
    begin
      if (state_r == st_xfer && op_r == cmd_rd_line && bus_rvalid)
        data_r[op_idx][beat_r] <= bus_rdata;
      // Write-through updates a valid line but never allocates one
      if (acc && req_write && rq_hit
          && (req_type == type_write_thru || req_type == type_write_back))
        data_r[rq_idx][f_beat(req_addr)][req_addr[HALF_LSB]*WORD_W +: WORD_W]
          <= req_wdata;
      if (state_r == st_done && op_r == cmd_rd_line && rq_write_r)
        data_r[op_idx][f_beat(rq_addr_r)][rq_addr_r[HALF_LSB]*WORD_W +: WORD_W]
          <= rq_wdata_r;
      if (state_r == st_xfer && op_r == cmd_rd_word && bus_rvalid)
        rd_beat_r <= bus_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Responses and bus data

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      rsp_valid_r <= 1'b0;
      rsp_rdata_r <= '0;
    end
    else if (ce)
    begin
      rsp_valid_r <= (acc && !needs_rd)
                     || (state_r == st_done && (op_r == cmd_rd_word || op_r == cmd_rd_line));
      if (acc && !needs_rd && !req_write)
        rsp_rdata_r <= f_word(data_r[rq_idx][f_beat(req_addr)], req_addr);
      else if (state_r == st_done && op_r == cmd_rd_word)
        rsp_rdata_r <= f_word(rd_beat_r, rq_addr_r);
      else if (state_r == st_done && op_r == cmd_rd_line && !rq_write_r)
        rsp_rdata_r <= f_word(data_r[op_idx][f_beat(rq_addr_r)], rq_addr_r);
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      bus_wdata_r <= '0;
      bus_be_r    <= '0;
    end
    else if (ce)
    begin
      if (snp_take && snp_dirty)
      begin
        bus_wdata_r <= data_r[f_idx(snp_addr)][0];
        bus_be_r    <= BE_ALL;
      end
      else if (acc && needs_rd && rq_cacheable && vict_dirty)
      begin
        bus_wdata_r <= data_r[rq_idx][0];
        bus_be_r    <= BE_ALL;
      end
      else if (drain_go)
      begin
        bus_wdata_r <= {2{wb.pop_data}};
        bus_be_r    <= wb.pop_addr[HALF_LSB] ? BE_HI : BE_LO;
      end
      else if (state_r == st_xfer && op_r == cmd_wr_line && bus_ack)
        bus_wdata_r <= data_r[op_idx][BEAT_CNT_W'(beat_r + 1'b1)];
    end
  end

  // Hit-modified stays asserted until the implicit write-back has finished
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      snoop_hit_modified_n_r    <= 1'b0;
      snp_hit_r <= 1'b0;
    end
    else if (ce)
    begin
      snp_hit_r <= snp_take && f_hit(snp_addr);
      if (snp_take && snp_dirty)
        snoop_hit_modified_n_r <= 1'b1;
      else if (state_r == st_done && iwb_r)
        snoop_hit_modified_n_r <= 1'b0;
    end
  end

  assign rsp_valid            = rsp_valid_r;
  assign rsp_rdata            = rsp_rdata_r;
  assign snp_hit              = snp_hit_r;
  assign snoop_hit_modified_n = !snoop_hit_modified_n_r;
  assign bus_req              = (state_r == st_req);
  assign bus_cmd              = op_r;
  assign bus_addr             = op_addr_r;
  assign bus_wdata            = bus_wdata_r;
  assign bus_be               = bus_be_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk iff ce);
  endclocking
  default disable iff (sys_rst);

  sequence s_iwb_start;
    !snoop_hit_modified_n && bus_req && bus_cmd == cmd_wr_line;
  endsequence
  sequence s_fill_last;
    state_r == st_xfer && op_r == cmd_rd_line && bus_rvalid && beat_r == LAST_BEAT;
  endsequence

  line_align_a: assert property (
    bus_req && bus_cmd == cmd_rd_line |-> bus_addr[LINE_OFS_W-1:0] == '0)
    else $error("line fill address not aligned");
  fill_beats_a: assert property (s_fill_last |=> state_r == st_done && !bus_req)
    else $error("fill did not end after fourth beat");
  read_hit_a: assert property (
    acc && !req_write && rq_cacheable && rq_hit |=> rsp_valid && state_r == st_idle)
    else $error("read hit went to the bus");
  buf_write_a: assert property (bus_req && bus_cmd == cmd_wr_word |-> !wb.empty)
    else $error("word write not from write buffer");
  snp_inval_a: assert property (
    snp_take && snp_write && f_hit(snp_addr) && !snp_dirty |=> !valid_r[$past(f_idx(snp_addr))])
    else $error("snooped write left shared line valid");
  snoop_hit_modified_n_wb_a: assert property (snp_take && snp_dirty |=> s_iwb_start)
    else $error("hit-modified without implicit write-back");
  uc_order_a: assert property (
    acc && req_type == type_uncached |=> $stable(valid_r) && wb.empty || !$past(needs_rd))
    else $error("uncached access allocated or overtook a write");
  uc_spec_a: assert property (
    req_valid && req_spec && req_type == type_uncached |-> !req_ready)
    else $error("speculative uncached access accepted");
  wt_noalloc_a: assert property (
    acc && req_write && req_type == type_write_thru && !rq_hit |=> $stable(valid_r))
    else $error("write-through store allocated a line");
  wb_alloc_a: assert property (
    acc && req_write && req_type == type_write_back && !rq_hit |=> bus_req ##[1:40] rsp_valid)
    else $error("write-back miss did not allocate");

endmodule : cmtp_cache_policy
`default_nettype wire

/* test/cmtp_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none
module cmtp_bus_model
  import cmtp_pkg::*;
(
  // Clock, reset, pace
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              slow,
  // Requests from the cache
  input  wire logic              bus_req,
  input  wire cmtp_cmd_e         bus_cmd,
  input  wire logic [ADDR_W-1:0] bus_addr,
  input  wire logic [BEAT_W-1:0] bus_wdata,
  input  wire logic [7:0]        bus_be,
  // Answers to the cache
  output var logic               bus_gnt,
  output var logic               bus_ack,
  output var logic               bus_rvalid,
  output var logic [BEAT_W-1:0]  bus_rdata,
  output var logic               busy
);
  logic [BEAT_W-1:0] mem [logic [ADDR_W-1:0]];
  int                cnt [8];
  int                beats = 0;
  int                gap   = 0;
  cmtp_cmd_e         cmd   = cmd_none;
  logic [ADDR_W-1:0] ba    = '0;

  function automatic logic [BEAT_W-1:0] rd(input logic [ADDR_W-1:0] a);
    return mem.exists(a) ? mem[a] : {~a, a};
  endfunction : rd

  //////////////////////////////////////////////
  initial
  begin
    {bus_gnt, bus_ack, bus_rvalid, busy} = 4'h0;
    bus_rdata = '0;
    foreach (cnt[k]) cnt[k] = 0;
  end

  always @(negedge clk)
  begin
    bus_gnt    <= 1'h0;
    bus_ack    <= 1'h0;
    bus_rvalid <= 1'h0;
    // Released data lines toggle so a stale beat never reads as valid
    bus_rdata  <= ~bus_rdata;
    if (sys_rst)
      busy <= 1'h0;
    else if (gap > 0)
      gap--;
    else if (busy === 1'h0 && bus_req === 1'h1)
    begin
      bus_gnt <= 1'h1;
      busy    <= 1'h1;
      cmd      = bus_cmd;
      ba       = {bus_addr[ADDR_W-1:3], 3'h0};
      beats    = (cmd == cmd_rd_line || cmd == cmd_wr_line) ? 4 : 1;
      cnt[cmd]++;
      gap      = slow ? 2 : 0;
    end
    else if (busy && beats > 0)
    begin
      if (cmd == cmd_rd_line || cmd == cmd_rd_word)
      begin
        bus_rvalid <= 1'h1;
        bus_rdata  <= rd(ba);
      end
      else
      begin
        bus_ack <= 1'h1;
        // Implicit write-backs land in memory too
        // Seed first so unwritten lanes keep the pattern instead of unknowns
        if (!mem.exists(ba)) mem[ba] = rd(ba);
        for (int b = 0; b < 8; b++) if (bus_be[b]) mem[ba][8*b+:8] = bus_wdata[8*b+:8];
      end
      ba = ba + 8;
      beats--;
      gap = slow ? 1 : 0;
    end
    else if (busy)
      busy <= 1'h0;
  end
endmodule : cmtp_bus_model
`default_nettype wire

/* test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb
  import cmtp_pkg::*;
;
  typedef struct {logic w; cmtp_mtype_e t; logic [31:0] a, d; logic [15:0] c;} cmtp_row_s;
  logic              clk = 1'h0, sys_rst = 1'h1, ce = 1'h1, slow = 1'h0;
  logic              req_valid = 1'h0, req_write = 1'h0, req_spec = 1'h0;
  logic              snp_valid = 1'h0, snp_write = 1'h0;
  cmtp_mtype_e       req_type = type_uncached;
  logic [ADDR_W-1:0] req_addr = '0, snp_addr = '0, bus_addr;
  logic [WORD_W-1:0] req_wdata = '0, rsp_rdata;
  logic              req_ready, rsp_valid, snp_ready, snp_hit, snoop_hit_modified_n;
  logic              bus_req, bus_gnt, bus_ack, bus_rvalid, busy;
  cmtp_cmd_e         bus_cmd;
  logic [BEAT_W-1:0] bus_wdata, bus_rdata;
  logic [7:0]        bus_be;
  int                failures = 0, samples_checked = 0, cycles = 0;
  cmtp_cmd_e         ck [4] = '{cmd_rd_line, cmd_rd_word, cmd_wr_line, cmd_wr_word};
  // Count nibbles: line reads, word reads, line writes, word writes
  cmtp_row_s         rows [19] = '{
    '{1'h0, type_write_back, 32'h104, 32'hFFFFFEFF, 16'h1000},
    '{1'h0, type_write_back, 32'h118, 32'h118, 16'h0000},
    '{1'h1, type_write_back, 32'h108, 32'h1234, 16'h0000},
    '{1'h0, type_write_back, 32'h108, 32'h1234, 16'h0000},
    '{1'h1, type_write_thru, 32'h220, 32'hAAAA, 16'h0001},
    '{1'h0, type_write_thru, 32'h224, 32'hFFFFFDDF, 16'h1000},
    '{1'h0, type_write_thru, 32'h220, 32'hAAAA, 16'h0000},
    '{1'h1, type_write_thru, 32'h224, 32'hBEEF, 16'h0001},
    '{1'h0, type_write_thru, 32'h224, 32'hBEEF, 16'h0000},
    '{1'h0, type_uncached, 32'h300, 32'h300, 16'h0100},
    '{1'h1, type_uncached, 32'h308, 32'hC0DE, 16'h0001},
    '{1'h0, type_uncached, 32'h308, 32'hC0DE, 16'h0100},
    '{1'h0, type_combining, 32'h404, 32'hFFFFFBFF, 16'h0100},
    '{1'h0, type_combining, 32'h404, 32'hFFFFFBFF, 16'h0100},
    '{1'h0, type_write_prot, 32'h540, 32'h540, 16'h1000},
    '{1'h1, type_write_prot, 32'h540, 32'h7777, 16'h0001},
    '{1'h0, type_write_prot, 32'h540, 32'h7777, 16'h1000},
    '{1'h1, type_write_back, 32'h700, 32'h55, 16'h1010},
    '{1'h0, type_write_back, 32'h700, 32'h55, 16'h0000}};

  cmtp_cache_policy i_cmtp_cache_policy (.clk, .sys_rst, .ce, .req_valid, .req_ready,
    .req_write, .req_spec, .req_type, .req_addr, .req_wdata, .rsp_valid, .rsp_rdata,
    .snp_valid, .snp_ready, .snp_addr, .snp_write, .snp_hit, .snoop_hit_modified_n,
    .bus_req, .bus_gnt, .bus_cmd, .bus_addr, .bus_wdata, .bus_be, .bus_ack,
    .bus_rvalid, .bus_rdata);
  cmtp_bus_model i_cmtp_bus_model (.clk, .sys_rst, .slow, .bus_req, .bus_cmd, .bus_addr,
    .bus_wdata, .bus_be, .bus_gnt, .bus_ack, .bus_rvalid, .bus_rdata, .busy);

  always #20 clk = ~clk;

  //////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : conclude

  task automatic chk32(input string what, input logic [31:0] exp, got);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : chk32

  // Bus counts only settle once the write buffer has drained
  task automatic settle();
    int q = 0;
    int n = 0;
    while (q < 4 && n < 400)
    begin
      @(negedge clk);
      q = (bus_req === 1'h0 && busy === 1'h0) ? q + 1 : 0;
      n++;
    end
  endtask : settle

  task automatic op(input logic w, input cmtp_mtype_e t, input logic [31:0] a, d,
                    input logic [15:0] c);
    int n = 0;
    int base [4];
    foreach (base[k]) base[k] = i_cmtp_bus_model.cnt[ck[k]];
    @(negedge clk);
    {req_valid, req_write, req_addr, req_wdata} = {1'h1, w, a, d};
    req_type = t;
    #1;
    while (req_ready !== 1'h1 && n < 300) begin @(negedge clk); #1; n++; end
    @(negedge clk);
    req_valid = 1'h0;
    while (rsp_valid !== 1'h1 && n < 600) begin @(negedge clk); n++; end
    chk32("response", 32'h1, 32'(rsp_valid));
    if (!w) chk32("read data", d, rsp_rdata);
    settle();
    foreach (base[k])
      chk32("bus op count", 32'(c[15-4*k-:4]), 32'(i_cmtp_bus_model.cnt[ck[k]] - base[k]));
  endtask : op

  task automatic snoop(input logic w, input logic [31:0] a, input logic hm_n,
                       input logic [31:0] wl);
    int n = 0;
    int base = i_cmtp_bus_model.cnt[cmd_wr_line];
    @(negedge clk);
    {snp_valid, snp_write, snp_addr} = {1'h1, w, a};
    #1;
    while (snp_ready !== 1'h1 && n < 300) begin @(negedge clk); #1; n++; end
    @(negedge clk);
    snp_valid = 1'h0;
    chk32("snoop hit", 32'h1, 32'(snp_hit));
    chk32("hit modified", 32'(hm_n), 32'(snoop_hit_modified_n));
    settle();
    chk32("write-back count", wl, 32'(i_cmtp_bus_model.cnt[cmd_wr_line] - base));
  endtask : snoop

  //////////////////////////////////////////////
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      failures++;
      conclude();
    end
  end

  initial
  begin
    repeat (3) @(negedge clk);
    sys_rst = 1'h0;
    foreach (rows[i])
    begin
      slow = (i >= 9);
      op(rows[i].w, rows[i].t, rows[i].a, rows[i].d, rows[i].c);
    end
    snoop(1'h0, 32'h700, 1'h0, 32'h1);
    op(1'h0, type_uncached, 32'h700, 32'h55, 16'h0100);
    op(1'h0, type_write_back, 32'h700, 32'h55, 16'h0000);
    snoop(1'h1, 32'h220, 1'h1, 32'h0);
    op(1'h0, type_write_thru, 32'h224, 32'hBEEF, 16'h1000);
    // Speculative uncached access must be held off indefinitely
    @(negedge clk);
    {req_valid, req_spec, req_write, req_addr} = {3'h6, 32'h300};
    req_type = type_uncached;
    repeat (4) @(negedge clk);
    chk32("spec ready", 32'h0, 32'(req_ready));
    chk32("spec bus req", 32'h0, 32'(bus_req));
    {req_valid, req_spec} = 2'h0;
    sys_rst = 1'h1;
    repeat (3) @(negedge clk);
    chk32("reset bus req", 32'h0, 32'(bus_req));
    chk32("reset hit modified", 32'h1, 32'(snoop_hit_modified_n));
    sys_rst = 1'h0;
    op(1'h0, type_write_back, 32'h108, 32'h1234, 16'h1000);
    conclude();
  end
endmodule : tb
`default_nettype wire
